// >>> sfr_bank_pkg.sv
package sfr_bank_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_STACK_POINTER   = 8'h81;
    localparam logic [7:0] ADDR_P0_MODE_A       = 8'h84;
    localparam logic [7:0] ADDR_P0_MODE_B       = 8'h85;
    localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
    localparam logic [7:0] ADDR_TIMER_CONTROL   = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE      = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_LOW      = 8'h8A;
    localparam logic [7:0] ADDR_TIMER1_LOW      = 8'h8B;
    localparam logic [7:0] ADDR_TIMER0_HIGH     = 8'h8C;
    localparam logic [7:0] ADDR_TIMER1_HIGH     = 8'h8D;
    localparam logic [7:0] ADDR_PORT1_LATCH     = 8'h90;
    localparam logic [7:0] ADDR_P1_MODE_A       = 8'h91;
    localparam logic [7:0] ADDR_P1_MODE_B       = 8'h92;
    localparam logic [7:0] ADDR_CPU_CLOCK_DIV   = 8'h95;
    localparam logic [7:0] ADDR_SERIAL_CONTROL  = 8'h98;
    localparam logic [7:0] ADDR_SERIAL_BUFFER   = 8'h99;
    localparam logic [7:0] ADDR_PORT2_LATCH     = 8'hA0;
    localparam logic [7:0] ADDR_P2_MODE_A       = 8'hA4;
    localparam logic [7:0] ADDR_P2_MODE_B       = 8'hA5;
    localparam logic [7:0] ADDR_WATCHDOG_FEED   = 8'hA6;
    localparam logic [7:0] ADDR_WATCHDOG_CTRL   = 8'hA7;
    localparam logic [7:0] ADDR_SLAVE_ADDRESS   = 8'hA9;
    localparam logic [7:0] ADDR_COMPARATOR1     = 8'hAC;
    localparam logic [7:0] ADDR_COMPARATOR2     = 8'hAD;
    localparam logic [7:0] ADDR_ADDRESS_MASK    = 8'hB9;
    localparam logic [7:0] ADDR_STATUS_WORD     = 8'hD0;
    localparam logic [7:0] ADDR_PORT0_IN_OFF    = 8'hF6;
    localparam logic [7:0] ADDR_PORT0           = 8'h80;

    // Reset values
    localparam logic [7:0] RST_ZERO             = 8'h00;
    localparam logic [7:0] RST_STACK_POINTER    = 8'h07;
    localparam logic [7:0] RST_PORT_HIGH        = 8'hFF;

    // Implemented-bit masks; others read unknown
    localparam logic [7:0] MASK_P1_MODE         = 8'hD3;
    localparam logic [7:0] MASK_P2_MODE_B       = 8'h03;
    localparam logic [7:0] MASK_PORT2           = 8'h03;
    localparam logic [7:0] MASK_WATCHDOG        = 8'h3F;
    localparam logic [7:0] MASK_COMPARATOR      = 8'h3F;
    localparam logic [7:0] MASK_POWER_CONTROL_CLEARED    = 8'hCF;

    // Power control bit positions
    localparam int POWER_CONTROL_BROWNOUT_BIT = 5;
    localparam int POWER_CONTROL_POWER_ON_BIT = 4;

    // Comparator control bit positions
    localparam int CMP_ENABLE_BIT = 5;
    localparam int CMP_POS_BIT    = 4;
    localparam int CMP_NEG_BIT    = 3;
    localparam int CMP_OUTEN_BIT  = 2;
    localparam int CMP_OUT_BIT    = 1;
    localparam int CMP_FLAG_BIT   = 0;

    // Machine cycle lengths in CPU clock ticks
    localparam logic [3:0] CYCLE_FAST     = 4'h6;
    localparam logic [3:0] CYCLE_STANDARD = 4'hC;

    // Register bus request from the CPU core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;

    // Analog comparator inputs (already digitised comparisons)
    typedef struct packed {
        logic a_gt_b;   // CINnA above CINnB is not meaningful; see module
        logic a_gt_ref_pin;
        logic b_gt_ref_pin;
        logic a_gt_ref_int;
        logic b_gt_ref_int;
    } cmp_in_type;
endpackage

// >>> sfr_bank.sv
`timescale 1ns/100ps
module sfr_bank
    import sfr_bank_pkg::*;
#(
    parameter int DIV_WIDTH = 8     // Width of cpu_clock_divider register
) (
    input  wire logic        core_clk_in,         // Oscillator clock
    input  wire logic        rst_in,              // Async reset, high
    input  wire sfr_req_type req_in,              // CPU register request
    input  wire logic        mcycle_ack_in,       // Unused hook kept low
    input  wire logic        standard_timing_select_in, // Config: 12-clock cycles
    input  wire logic        port_reset_level_select_in, // Config: ports reset high
    input  wire logic        power_up_in,         // Pulse at supply rise
    input  wire logic        brownout_in,         // Pulse on brownout event
    input  wire logic        watchdog_reset_in,   // Current reset is watchdog
    input  wire logic [7:0]  port0_pins_in,       // Port 0 pin levels
    input  wire logic [7:0]  port1_pins_in,       // Port 1 pin levels
    input  wire cmp_in_type  cmp1_in,             // Comparator 1 analog results
    input  wire cmp_in_type  cmp2_in,             // Comparator 2 analog results
    output logic [7:0]       rdata_out,           // Read data
    output logic             cpu_clk_en_out,      // CPU clock enable pulse
    output logic             mcycle_en_out,       // Machine cycle pulse
    output logic [7:0]       port0_in_buf_en_out, // Port 0 input buffers on
    output logic [7:0]       port1_out,           // Port 1 latch
    output logic [7:0]       port2_out,           // Port 2 latch
    output logic [1:0]       cmp_pin_out,         // Comparator pin outputs
    output logic [1:0]       cmp_irq_out          // Comparator flags
);
    // Registers
    logic [7:0]           sp_ff, port0_output_mode_a_ff, port0_output_mode_b_ff, timer_control_ff, timer_mode_ff;
    logic [7:0]           tl0_ff, tl1_ff, th0_ff, th1_ff;
    logic [7:0]           p1_ff, port1_output_mode_a_ff, port1_output_mode_b_ff, serial_control_ff, serial_buffer_ff;
    logic [7:0]           p2_ff, port2_mode_and_output_select_ff, port2_output_mode_b_ff, watchdog_control_ff;
    logic [7:0]           serial_slave_address_ff, serial_address_mask_ff, psw_ff, in_off_ff;
    logic [5:0]           power_control_low_ff;       // Cleared bits 7:6,3:0 kept here
    logic                 brownout_flag_ff;  // Retained over reset
    logic                 power_on_flag_ff;  // Retained over reset
    logic [DIV_WIDTH-1:0] div_ff;            // cpu_clock_divider
    logic [DIV_WIDTH-1:0] div_cnt_ff;        // Divider counter
    logic [3:0]           osc_cnt_ff;        // CPU clocks in machine cycle
    logic [7:0]           cmp1_ff, cmp2_ff;  // Comparator control
    logic                 ports_loaded_ff;   // Port reset level captured
    logic                 wd_loaded_ff;      // Watchdog reset value applied
    logic [7:0]           rdata_ff;          // Read data register
    logic                 wr;                // Write strobe
    logic [3:0]           cycle_len;         // Selected cycle length
    logic [1:0]           nxt_cmp_out;       // Raw comparator results

    // Write strobe: CPU request taken every oscillator clock
    assign wr = req_in.wr;

    // Machine cycle length selection
    assign cycle_len = standard_timing_select_in ? CYCLE_STANDARD
                                                 : CYCLE_FAST;

    // CPU clock divider: pulse every div+1 oscillator clocks
    // Compare by >= so a lowered divide value cannot strand the count
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt_ff <= '0;
        end else if (div_cnt_ff >= div_ff) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end
    assign cpu_clk_en_out = (div_cnt_ff >= div_ff);

    // Machine cycle counter in CPU clock ticks
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_cnt_ff <= 4'h0;
        end else if (cpu_clk_en_out) begin
            if (osc_cnt_ff >= cycle_len - 4'h1) begin
                osc_cnt_ff <= 4'h0;
            end else begin
                osc_cnt_ff <= osc_cnt_ff + 4'h1;
            end
        end
    end
    assign mcycle_en_out = cpu_clk_en_out && (osc_cnt_ff >= cycle_len - 4'h1);

    // Plain read/write registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sp_ff    <= RST_STACK_POINTER;
            port0_output_mode_a_ff  <= RST_ZERO;
            port0_output_mode_b_ff  <= RST_ZERO;
            timer_control_ff  <= RST_ZERO;
            timer_mode_ff  <= RST_ZERO;
            tl0_ff   <= RST_ZERO;
            tl1_ff   <= RST_ZERO;
            th0_ff   <= RST_ZERO;
            th1_ff   <= RST_ZERO;
            port1_output_mode_a_ff  <= RST_ZERO;
            port1_output_mode_b_ff  <= RST_ZERO;
            serial_control_ff  <= RST_ZERO;
            serial_buffer_ff  <= RST_ZERO;
            port2_mode_and_output_select_ff  <= RST_ZERO;
            port2_output_mode_b_ff  <= RST_ZERO;
            serial_slave_address_ff <= RST_ZERO;
            serial_address_mask_ff <= RST_ZERO;
            psw_ff   <= RST_ZERO;
            in_off_ff <= RST_ZERO;
            div_ff   <= '0;
        end else if (wr) begin
            // Decode by address
            case (req_in.addr)
                ADDR_STACK_POINTER:  sp_ff    <= req_in.wdata;
                ADDR_P0_MODE_A:      port0_output_mode_a_ff  <= req_in.wdata;
                ADDR_P0_MODE_B:      port0_output_mode_b_ff  <= req_in.wdata;
                ADDR_TIMER_CONTROL:  timer_control_ff  <= req_in.wdata;
                ADDR_TIMER_MODE:     timer_mode_ff  <= req_in.wdata;
                ADDR_TIMER0_LOW:     tl0_ff   <= req_in.wdata;
                ADDR_TIMER1_LOW:     tl1_ff   <= req_in.wdata;
                ADDR_TIMER0_HIGH:    th0_ff   <= req_in.wdata;
                ADDR_TIMER1_HIGH:    th1_ff   <= req_in.wdata;
                ADDR_P1_MODE_A:      port1_output_mode_a_ff  <= req_in.wdata & MASK_P1_MODE;
                ADDR_P1_MODE_B:      port1_output_mode_b_ff  <= req_in.wdata & MASK_P1_MODE;
                ADDR_SERIAL_CONTROL: serial_control_ff  <= req_in.wdata;
                ADDR_SERIAL_BUFFER:  serial_buffer_ff  <= req_in.wdata;
                ADDR_P2_MODE_A:      port2_mode_and_output_select_ff  <= req_in.wdata;
                ADDR_P2_MODE_B:      port2_output_mode_b_ff  <= req_in.wdata & MASK_P2_MODE_B;
                ADDR_SLAVE_ADDRESS:  serial_slave_address_ff <= req_in.wdata;
                ADDR_ADDRESS_MASK:   serial_address_mask_ff <= req_in.wdata;
                ADDR_STATUS_WORD:    psw_ff   <= req_in.wdata;
                ADDR_PORT0_IN_OFF:   in_off_ff <= req_in.wdata;
                ADDR_CPU_CLOCK_DIV:  div_ff   <= req_in.wdata[DIV_WIDTH-1:0];
                default: ;                                  // Other addresses
            endcase
        end
    end

    // Port latches: reset level taken from config after release
    // A write in the load cycle is dropped; requests start one edge later
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            p1_ff           <= RST_ZERO;
            p2_ff           <= RST_ZERO;
            ports_loaded_ff <= 1'b0;
        end else if (!ports_loaded_ff) begin
            p1_ff           <= port_reset_level_select_in ? RST_PORT_HIGH : RST_ZERO;
            p2_ff           <= port_reset_level_select_in ? MASK_PORT2 : RST_ZERO;
            ports_loaded_ff <= 1'b1;
        end else if (wr && req_in.addr == ADDR_PORT1_LATCH) begin
            p1_ff <= req_in.wdata;
        end else if (wr && req_in.addr == ADDR_PORT2_LATCH) begin
            p2_ff <= req_in.wdata & MASK_PORT2;
        end
    end

    // Power control cleared bits
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_control_low_ff <= 6'h00;
        end else if (wr && req_in.addr == ADDR_POWER_CONTROL) begin
            power_control_low_ff <= {req_in.wdata[7:6], req_in.wdata[3:0]};
        end
    end

    // Retained flags: no reset term; set wins over software clear
    // Flags stay unknown until set by a pulse or by a power control write
    always_ff @(posedge core_clk_in) begin
        if (power_up_in) begin
            power_on_flag_ff <= 1'b1;
        end else if (wr && req_in.addr == ADDR_POWER_CONTROL) begin
            power_on_flag_ff <= req_in.wdata[POWER_CONTROL_POWER_ON_BIT];
        end
        if (power_up_in || brownout_in) begin
            brownout_flag_ff <= 1'b1;
        end else if (wr && req_in.addr == ADDR_POWER_CONTROL) begin
            brownout_flag_ff <= req_in.wdata[POWER_CONTROL_BROWNOUT_BIT];
        end
    end

    // Watchdog control: cleared by every reset, watchdog reset included
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wd_loaded_ff <= 1'b0;
            watchdog_control_ff     <= RST_ZERO;
        end else if (!wd_loaded_ff) begin
            wd_loaded_ff <= 1'b1;
            if (watchdog_reset_in) begin
                watchdog_control_ff <= watchdog_control_ff;                       // Zero loaded at reset kept
            end
        end else if (wr && req_in.addr == ADDR_WATCHDOG_CTRL) begin
            watchdog_control_ff <= req_in.wdata & MASK_WATCHDOG;
        end
    end

    // Comparator decisions
    assign nxt_cmp_out[0] = cmp1_ff[CMP_POS_BIT]
        ? (cmp1_ff[CMP_NEG_BIT] ? cmp1_in.b_gt_ref_int : cmp1_in.b_gt_ref_pin)
        : (cmp1_ff[CMP_NEG_BIT] ? cmp1_in.a_gt_ref_int : cmp1_in.a_gt_ref_pin);
    assign nxt_cmp_out[1] = cmp2_ff[CMP_POS_BIT]
        ? (cmp2_ff[CMP_NEG_BIT] ? cmp2_in.b_gt_ref_int : cmp2_in.b_gt_ref_pin)
        : (cmp2_ff[CMP_NEG_BIT] ? cmp2_in.a_gt_ref_int : cmp2_in.a_gt_ref_pin);

    // Comparator 1 control, output and change flag
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmp1_ff <= RST_ZERO;
        end else begin
            if (wr && req_in.addr == ADDR_COMPARATOR1) begin
                cmp1_ff[5:2] <= req_in.wdata[5:2];
                cmp1_ff[CMP_FLAG_BIT] <= req_in.wdata[CMP_FLAG_BIT];
            end
            if (!cmp1_ff[CMP_ENABLE_BIT]) begin
                cmp1_ff[CMP_OUT_BIT]  <= 1'b0;
                cmp1_ff[CMP_FLAG_BIT] <= 1'b0;
            end else begin
                cmp1_ff[CMP_OUT_BIT] <= nxt_cmp_out[0];
                if (nxt_cmp_out[0] != cmp1_ff[CMP_OUT_BIT]) begin
                    cmp1_ff[CMP_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    // Comparator 2 control, output and change flag
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmp2_ff <= RST_ZERO;
        end else begin
            if (wr && req_in.addr == ADDR_COMPARATOR2) begin
                cmp2_ff[5:2] <= req_in.wdata[5:2];
                cmp2_ff[CMP_FLAG_BIT] <= req_in.wdata[CMP_FLAG_BIT];
            end
            if (!cmp2_ff[CMP_ENABLE_BIT]) begin
                cmp2_ff[CMP_OUT_BIT]  <= 1'b0;
                cmp2_ff[CMP_FLAG_BIT] <= 1'b0;
            end else begin
                cmp2_ff[CMP_OUT_BIT] <= nxt_cmp_out[1];
                if (nxt_cmp_out[1] != cmp2_ff[CMP_OUT_BIT]) begin
                    cmp2_ff[CMP_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    // Read data mux, registered
    // Unimplemented bits read zero, one legal value for unknown bits
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= RST_ZERO;
        end else if (req_in.rd) begin
            case (req_in.addr)
                ADDR_PORT0:          rdata_ff <= port0_pins_in & ~in_off_ff;
                ADDR_STACK_POINTER:  rdata_ff <= sp_ff;
                ADDR_P0_MODE_A:      rdata_ff <= port0_output_mode_a_ff;
                ADDR_P0_MODE_B:      rdata_ff <= port0_output_mode_b_ff;
                ADDR_POWER_CONTROL:  rdata_ff <= {power_control_low_ff[5:4], brownout_flag_ff,
                                                  power_on_flag_ff, power_control_low_ff[3:0]};
                ADDR_TIMER_CONTROL:  rdata_ff <= timer_control_ff;
                ADDR_TIMER_MODE:     rdata_ff <= timer_mode_ff;
                ADDR_TIMER0_LOW:     rdata_ff <= tl0_ff;
                ADDR_TIMER1_LOW:     rdata_ff <= tl1_ff;
                ADDR_TIMER0_HIGH:    rdata_ff <= th0_ff;
                ADDR_TIMER1_HIGH:    rdata_ff <= th1_ff;
                ADDR_PORT1_LATCH:    rdata_ff <= port1_pins_in;
                ADDR_P1_MODE_A:      rdata_ff <= port1_output_mode_a_ff;
                ADDR_P1_MODE_B:      rdata_ff <= port1_output_mode_b_ff;
                ADDR_CPU_CLOCK_DIV:  rdata_ff <= 8'(div_ff);
                ADDR_SERIAL_CONTROL: rdata_ff <= serial_control_ff;
                ADDR_SERIAL_BUFFER:  rdata_ff <= serial_buffer_ff;
                ADDR_PORT2_LATCH:    rdata_ff <= p2_ff;
                ADDR_P2_MODE_A:      rdata_ff <= port2_mode_and_output_select_ff;
                ADDR_P2_MODE_B:      rdata_ff <= port2_output_mode_b_ff;
                ADDR_WATCHDOG_CTRL:  rdata_ff <= watchdog_control_ff;
                ADDR_SLAVE_ADDRESS:  rdata_ff <= serial_slave_address_ff;
                ADDR_COMPARATOR1:    rdata_ff <= cmp1_ff & MASK_COMPARATOR;
                ADDR_COMPARATOR2:    rdata_ff <= cmp2_ff & MASK_COMPARATOR;
                ADDR_ADDRESS_MASK:   rdata_ff <= serial_address_mask_ff;
                ADDR_STATUS_WORD:    rdata_ff <= psw_ff;
                ADDR_PORT0_IN_OFF:   rdata_ff <= in_off_ff;
                default:             rdata_ff <= RST_ZERO;  // Feed register and unmapped
            endcase
        end
    end

    // Outputs
    // Pin gated by its enable; a disabled comparator drives low
    assign rdata_out           = rdata_ff;
    assign port0_in_buf_en_out = ~in_off_ff;
    assign port1_out           = p1_ff;
    assign port2_out           = p2_ff;
    assign cmp_pin_out         = {cmp2_ff[CMP_OUT_BIT] & cmp2_ff[CMP_OUTEN_BIT],
                                  cmp1_ff[CMP_OUT_BIT] & cmp1_ff[CMP_OUTEN_BIT]};
    assign cmp_irq_out         = {cmp2_ff[CMP_FLAG_BIT], cmp1_ff[CMP_FLAG_BIT]};

    // Machine cycle length in fast mode with divider off
    a_fast_cycle_len: assert property (@(posedge core_clk_in)
        disable iff (rst_in || (wr && req_in.addr == ADDR_CPU_CLOCK_DIV))
        (mcycle_en_out && div_ff == '0 && !standard_timing_select_in
         && $stable(standard_timing_select_in))
        |=> !mcycle_en_out [*5] ##1 mcycle_en_out)
        else $error("fast machine cycle not six clocks");
    // Machine cycle length in standard mode; a divider write aborts the check
    a_std_cycle_len: assert property (@(posedge core_clk_in)
        disable iff (rst_in || (wr && req_in.addr == ADDR_CPU_CLOCK_DIV))
        (mcycle_en_out && div_ff == '0 && standard_timing_select_in)
        |=> !mcycle_en_out [*5] ##1 !mcycle_en_out [*6] ##1 mcycle_en_out)
        else $error("standard machine cycle not twelve clocks");
    // Divider pulse spacing
    a_div_spacing: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cpu_clk_en_out && div_ff == DIV_WIDTH'(1) && $stable(div_ff))
        |-> ##1 !cpu_clk_en_out ##1 cpu_clk_en_out)
        else $error("cpu clock divide by two wrong");
    // Disabled port 0 pins read zero
    a_port0_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.rd && req_in.addr == ADDR_PORT0) |=> ((rdata_out & $past(in_off_ff)) == 8'h00))
        else $error("disabled port 0 pin read nonzero");
    // Input buffer follows disable register
    a_in_buf_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr && req_in.addr == ADDR_PORT0_IN_OFF) |=> (port0_in_buf_en_out == ~$past(req_in.wdata)))
        else $error("input buffer enable wrong");
    // Power-on flag set after supply up
    a_power_on_set: assert property (@(posedge core_clk_in)
        power_up_in |=> power_on_flag_ff && brownout_flag_ff)
        else $error("power flags not set at power up");
    // Brownout flag set after brownout
    a_brownout_set: assert property (@(posedge core_clk_in)
        brownout_in |=> brownout_flag_ff)
        else $error("brownout flag not set");
    // Comparator change sets flag
    a_cmp_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cmp1_ff[CMP_ENABLE_BIT] && nxt_cmp_out[0] != cmp1_ff[CMP_OUT_BIT]) |=> cmp_irq_out[0])
        else $error("comparator change flag missing");
    // Write reaches register next cycle
    a_sp_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr && req_in.addr == ADDR_STACK_POINTER) |=> sp_ff == $past(req_in.wdata))
        else $error("stack pointer write lost");

    // Comparator 2 change sets its flag
    a_cmp2_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cmp2_ff[CMP_ENABLE_BIT] && nxt_cmp_out[1] != cmp2_ff[CMP_OUT_BIT]) |=> cmp_irq_out[1])
        else $error("comparator 2 change flag missing");

    // Disabled comparator clears output and flag
    a_cmp_off_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !cmp1_ff[CMP_ENABLE_BIT] |=> !cmp_irq_out[0] && !cmp_pin_out[0])
        else $error("disabled comparator not cleared");

    // Comparator 1 result follows selected inputs
    a_cmp_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
        cmp1_ff[CMP_ENABLE_BIT] |=> cmp1_ff[CMP_OUT_BIT] == $past(nxt_cmp_out[0]))
        else $error("comparator 1 result wrong");

    // Comparator 2 result follows selected inputs
    a_cmp2_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
        cmp2_ff[CMP_ENABLE_BIT] |=> cmp2_ff[CMP_OUT_BIT] == $past(nxt_cmp_out[1]))
        else $error("comparator 2 result wrong");

    // Cleared power control bits after reset
    a_power_control_cleared: assert property (@(posedge core_clk_in)
        $fell(rst_in) |-> power_control_low_ff == '0)
        else $error("power control bits not cleared");

    // Watchdog control low bits after other resets
    a_wd_reset_val: assert property (@(posedge core_clk_in)
        ($fell(rst_in) && !watchdog_reset_in) |-> (watchdog_control_ff & MASK_WATCHDOG) == RST_ZERO)
        else $error("watchdog control reset value wrong");

    // Port 1 latch loads the configured level
    a_port_load: assert property (@(posedge core_clk_in)
        $fell(rst_in) |=> port1_out == ($past(port_reset_level_select_in)
                                        ? RST_PORT_HIGH : RST_ZERO))
        else $error("port reset level wrong");

    // Feed register reads back zero
    a_feed_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.rd && req_in.addr == ADDR_WATCHDOG_FEED) |=> rdata_out == RST_ZERO)
        else $error("feed register read nonzero");

    // Stack pointer read returns the register
    a_sp_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.rd && req_in.addr == ADDR_STACK_POINTER) |=> rdata_out == $past(sp_ff))
        else $error("stack pointer read wrong");
endmodule

// >>> cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model
    import sfr_bank_pkg::*;
(
    input  wire logic   clk_in,  // Oscillator clock
    output sfr_req_type req_out  // Request to the bank
);
    // Bus idle at time zero
    initial begin
        req_out = '0;
    end
    // Idle bus after a write carries inverted address and data with both strobes low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= {2'h0, ~a, ~d};
    endtask
    // Read strobe held for one taken edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        req_out <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        req_out <= {2'h0, ~a, 8'hA5};
    endtask
endmodule

// >>> sfr_map_power_flags_timing_tb.sv
`timescale 1ns/100ps
module sfr_map_power_flags_timing_tb;
    import sfr_bank_pkg::*;
    logic        clk = 0, rst = 1, std = 0, lvl = 0, pwr = 0, bo = 0; // Stimulus
    logic        rd_pend = 0, cpu_en, mc_en;  // Monitor state, timing pulses
    logic [7:0]  p0 = 0, p1 = 0, rdata, p0_buf, p1_out, p2_out, v, w; // Data
    logic [1:0]  cmp_pin, cmp_irq;            // Comparator outputs
    cmp_in_type  c1 = '0, c2 = '0;            // Comparator inputs
    sfr_req_type req;                         // Core request
    logic [7:0]  exp_q[$];                    // Expected read data
    logic [7:0]  rw[8] = '{ADDR_STACK_POINTER, ADDR_P0_MODE_A, ADDR_P0_MODE_B,
        ADDR_TIMER_MODE, ADDR_TIMER0_LOW, ADDR_TIMER1_HIGH, ADDR_SLAVE_ADDRESS,
        ADDR_ADDRESS_MASK};                   // Plain read-write registers
    int          miscompares = 0, cmp_count = 0, n; // Counters
    always #50 clk = ~clk;
    cpu_core_model cpu_core_model_inst (.clk_in(clk), .req_out(req));
    sfr_bank sfr_bank_inst (.core_clk_in(clk), .rst_in(rst), .req_in(req),
        .mcycle_ack_in(1'b0), .standard_timing_select_in(std),
        .port_reset_level_select_in(lvl), .power_up_in(pwr), .brownout_in(bo),
        .watchdog_reset_in(1'b0), .port0_pins_in(p0), .port1_pins_in(p1),
        .cmp1_in(c1), .cmp2_in(c2), .rdata_out(rdata), .cpu_clk_en_out(cpu_en),
        .mcycle_en_out(mc_en), .port0_in_buf_en_out(p0_buf), .port1_out(p1_out),
        .port2_out(p2_out), .cmp_pin_out(cmp_pin), .cmp_irq_out(cmp_irq));
    // Verdict and end of run
    task automatic stop_test();
        $display("Compares %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One comparison
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read with its expectation noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu_core_model_inst.rd(a);
    endtask
    // Reset held 12 cycles, first request taken on the 4th edge after
    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Clocks between two machine-cycle pulses, bounded
    task automatic mc_period(input int exp);
        n = 0;
        do @(negedge clk); while (mc_en !== 1'b1 && ++n < 60);
        n = 0;
        do @(negedge clk); while (mc_en !== 1'b1 && ++n < 60);
        check(8'(n + 1), 8'(exp));
        if (n >= 60)
            stop_test();
    endtask
    // Monitor: read data one cycle after the taken read
    always @(posedge clk) rd_pend <= req.rd;
    always @(negedge clk) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0)
            check(rdata, exp_q.pop_front());
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    // Main sequence
    initial begin
        void'($urandom(35539));
        do_reset();
        rd(ADDR_STACK_POINTER, RST_STACK_POINTER);
        rd(ADDR_TIMER_CONTROL, RST_ZERO);
        rd(ADDR_WATCHDOG_FEED, RST_ZERO);
        rd(8'h8F, RST_ZERO);
        foreach (rw[i]) begin
            v = 8'($urandom);
            cpu_core_model_inst.wr(rw[i], v);
            rd(rw[i], v);
        end
        v = 8'($urandom);
        w = 8'($urandom);
        p0 <= w;
        p1 <= ~w;
        cpu_core_model_inst.wr(ADDR_PORT0_IN_OFF, v);
        rd(ADDR_PORT0, w & ~v);
        rd(ADDR_PORT1_LATCH, ~w);
        check(p0_buf, ~v);
        pwr <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        rd(ADDR_POWER_CONTROL, 8'h30);
        cpu_core_model_inst.wr(ADDR_POWER_CONTROL, 8'hCF);
        bo <= 1'b1;
        @(posedge clk);
        bo <= 1'b0;
        rd(ADDR_POWER_CONTROL, 8'hEF);
        cpu_core_model_inst.wr(ADDR_WATCHDOG_CTRL, 8'h3F);
        lvl <= 1'b1;
        std <= 1'b1;
        do_reset();
        rd(ADDR_POWER_CONTROL, 8'h20);
        rd(ADDR_WATCHDOG_CTRL, 8'h00);
        check(p1_out, RST_PORT_HIGH);
        check(p2_out, MASK_PORT2);
        mc_period(12);
        lvl <= 1'b0;
        std <= 1'b0;
        do_reset();
        check(p1_out, RST_ZERO);
        mc_period(6);
        cpu_core_model_inst.wr(ADDR_CPU_CLOCK_DIV, 8'h01);
        mc_period(12);
        n = 0;
        repeat (4) begin
            @(negedge clk);
            n += cpu_en;
        end
        check(8'(n), 8'h02);
        cpu_core_model_inst.wr(ADDR_COMPARATOR1, 8'h24);
        repeat (6) @(posedge clk);
        c1 <= 5'h0A;
        repeat (8) @(posedge clk);
        check({6'h00, cmp_pin}, 8'h01);
        check({6'h00, cmp_irq}, 8'h01);
        rd(ADDR_COMPARATOR1, 8'h27);
        repeat (3) @(posedge clk);
        check(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
